// File: rtl/fan_drive_pkg.sv
// constants and types for the fan motor commutation and pwm logic
// Summary of operation
// - pwm only the source-side switches by command
// - duty spans fully off to fully on
// - clamp duty below low, above high thresholds
// - undervoltage holds all source switches off
// - overtemperature holds all source switches off
// - current limit cuts source switches each cycle
// - triple-rate tach combines all three inputs
// - halt high turns source switches off
// - halt low enables normal running
// - current limit leaves sink side short braking
// - low direction forward, high reverse
package fan_drive_pkg;
  localparam int CMD_W = 8;
  localparam logic [7:0] CMD_LOW_THRESHOLD_RST = 8'h20;
  localparam logic [7:0] CMD_HIGH_THRESHOLD_RST = 8'hE0;
  localparam int CLK_FREQ_HZ = 25_000_000;
  localparam int CARRIER_MAX_HZ = 40_000;
  localparam int CARRIER_STEPS = 256;
  // least prescale divide in cycles per ramp step, so the carrier stays at or below the ceiling
  localparam int CARRIER_DIV = (CLK_FREQ_HZ + CARRIER_MAX_HZ * CARRIER_STEPS - 1) / (CARRIER_MAX_HZ * CARRIER_STEPS);
  localparam logic [7:0] CARRIER_DIV_M1 = 8'(CARRIER_DIV - 1);
  localparam logic [2:0] PHASE_NONE = 3'h0;
endpackage : fan_drive_pkg

// File: rtl/sector_decode.sv
// hall sector to source and sink phase decoder
`timescale 1ns/100ps
module sector_decode
  import fan_drive_pkg::*;
(
  input wire logic [2:0] hall,
  input wire logic reverse,
  output logic [2:0] src_sel,
  output logic [2:0] snk_sel
);
  logic [2:0] fwd_src;
  logic [2:0] fwd_snk;

  // six valid sectors, illegal codes energize nothing
  always_comb begin
    unique case (hall)
      3'b001: begin fwd_src = 3'b001; fwd_snk = 3'b010; end
      3'b011: begin fwd_src = 3'b001; fwd_snk = 3'b100; end
      3'b010: begin fwd_src = 3'b010; fwd_snk = 3'b100; end
      3'b110: begin fwd_src = 3'b010; fwd_snk = 3'b001; end
      3'b100: begin fwd_src = 3'b100; fwd_snk = 3'b001; end
      3'b101: begin fwd_src = 3'b100; fwd_snk = 3'b010; end
      default: begin fwd_src = PHASE_NONE; fwd_snk = PHASE_NONE; end
    endcase
  end

  // reverse swaps source and sink, running the sequence backwards
  assign src_sel = reverse ? fwd_snk : fwd_src;
  assign snk_sel = reverse ? fwd_src : fwd_snk;
endmodule : sector_decode

// File: rtl/fan_drive_ctrl.sv
// commutation, direct pwm, protection and tach logic for a fan motor
`timescale 1ns/100ps
module fan_drive_ctrl
  import fan_drive_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  input wire logic [7:0] SPEED_COMMAND_LEVEL,
  input wire logic [7:0] SPEED_COMMAND_LOW_THRESHOLD,
  input wire logic [7:0] SPEED_COMMAND_HIGH_THRESHOLD,
  input wire logic HALT,
  input wire logic REVERSE,
  input wire logic UNDERVOLTAGE,
  input wire logic OVERHEAT,
  input wire logic CURRENT_LIMIT,
  input wire logic ROTOR_POSITION_A,
  input wire logic ROTOR_POSITION_B,
  input wire logic ROTOR_POSITION_C,
  output logic [2:0] SOURCE_DRIVE,
  output logic [2:0] SINK_DRIVE,
  output logic TACH_SINGLE_RATE,
  output logic TACH_TRIPLE_RATE,
  output logic LIMIT_ACTIVE,
  output logic RUNNING
);
  logic [7:0] prescale_reg;
  logic [7:0] prescale_next;
  logic [7:0] carrier_reg;
  logic [7:0] carrier_next;
  logic limit_latch_reg;
  logic limit_latch_next;
  logic [7:0] duty_reg;
  logic [7:0] duty_next;
  logic [2:0] src_reg;
  logic [2:0] snk_reg;
  logic tach1_reg;
  logic tach3_reg;
  logic limit_reg;
  logic run_reg;
  logic [2:0] hall;
  logic [2:0] src_sel;
  logic [2:0] snk_sel;
  logic carrier_wrap;
  logic below_low;
  logic above_high;
  logic [15:0] span_num;
  logic [7:0] span_den;
  logic [7:0] scaled;
  logic pwm_on;
  logic inhibit;
  logic src_enable;

  assign hall = {ROTOR_POSITION_C, ROTOR_POSITION_B, ROTOR_POSITION_A};

  sector_decode u_sector (
    .hall(hall),
    .reverse(REVERSE),
    .src_sel(src_sel),
    .snk_sel(snk_sel)
  );

  // carrier: prescaler then 8-bit ramp, period 256 ramp steps
  assign carrier_wrap = (prescale_reg == CARRIER_DIV_M1);
  assign prescale_next = carrier_wrap ? 8'h00 : 8'(prescale_reg + 8'h01);
  assign carrier_next = carrier_wrap ? 8'(carrier_reg + 8'h01) : carrier_reg;

  // duty map: clamp outside thresholds, linear between
  assign below_low = (SPEED_COMMAND_LEVEL <= SPEED_COMMAND_LOW_THRESHOLD);
  assign above_high = (SPEED_COMMAND_LEVEL >= SPEED_COMMAND_HIGH_THRESHOLD);
  // widen before the product so the full 16-bit result is kept
  assign span_num = 16'(SPEED_COMMAND_LEVEL - SPEED_COMMAND_LOW_THRESHOLD) * 16'h00FF;
  assign span_den = 8'(SPEED_COMMAND_HIGH_THRESHOLD - SPEED_COMMAND_LOW_THRESHOLD);
  assign scaled = (span_den == 8'h00) ? 8'hFF : 8'(span_num / span_den);
  assign duty_next = below_low ? 8'h00 : (above_high ? 8'hFF : scaled);

  // 0 duty never on; 255 duty held on through the whole carrier
  assign pwm_on = (duty_reg == 8'hFF) || (carrier_reg < duty_reg);

  // limit trips until next carrier period start (on/off peak control)
  assign limit_latch_next = CURRENT_LIMIT ? 1'b1 : ((carrier_wrap && carrier_reg == 8'hFF) ? 1'b0 : limit_latch_reg);

  assign inhibit = UNDERVOLTAGE || OVERHEAT || HALT;
  assign src_enable = !inhibit && pwm_on && !limit_latch_next;

  // pwm timebase and duty sampling
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      prescale_reg <= 8'h00;
      carrier_reg <= 8'h00;
      limit_latch_reg <= 1'b0;
      duty_reg <= 8'h00;
    end else if (CLK_EN) begin
      prescale_reg <= prescale_next;
      carrier_reg <= carrier_next;
      limit_latch_reg <= limit_latch_next;
      duty_reg <= duty_next;
    end
  end

  // phase drives; sink stays on under limit for short brake
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      src_reg <= PHASE_NONE;
      snk_reg <= PHASE_NONE;
      limit_reg <= 1'b0;
      run_reg <= 1'b0;
    end else if (CLK_EN) begin
      src_reg <= src_enable ? src_sel : PHASE_NONE;
      snk_reg <= inhibit ? PHASE_NONE : snk_sel;
      limit_reg <= limit_latch_next;
      run_reg <= !inhibit;
    end
  end

  // tach outputs: first input and three-input parity
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      tach1_reg <= 1'b0;
      tach3_reg <= 1'b0;
    end else if (CLK_EN) begin
      tach1_reg <= ROTOR_POSITION_A;
      tach3_reg <= ^hall;
    end
  end

  assign SOURCE_DRIVE = src_reg;
  assign SINK_DRIVE = snk_reg;
  assign TACH_SINGLE_RATE = tach1_reg;
  assign TACH_TRIPLE_RATE = tach3_reg;
  assign LIMIT_ACTIVE = limit_reg;
  assign RUNNING = run_reg;
endmodule : fan_drive_ctrl

// File: verification/fan_drive_ctrl_monitor.sv
// port assertions for the fan drive control logic
`timescale 1ns/100ps
module fan_drive_ctrl_monitor (
  input wire logic SYS_CLK, RESETN, CLK_EN, HALT, UNDERVOLTAGE, OVERHEAT, CURRENT_LIMIT, LIMIT_ACTIVE, RUNNING,
  input wire logic ROTOR_POSITION_A, ROTOR_POSITION_B, ROTOR_POSITION_C, TACH_SINGLE_RATE, TACH_TRIPLE_RATE,
  input wire logic [2:0] SOURCE_DRIVE, SINK_DRIVE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN || !CLK_EN);
  a_halt_src_off: assert property (HALT |=> SOURCE_DRIVE == 3'h0) else $error("source on in halt");
  a_uv_src_off: assert property (UNDERVOLTAGE |=> SOURCE_DRIVE == 3'h0) else $error("source on in uv");
  a_heat_src_off: assert property (OVERHEAT |=> SOURCE_DRIVE == 3'h0) else $error("source on in heat");
  a_limit_cut: assert property (CURRENT_LIMIT |=> SOURCE_DRIVE == 3'h0 && LIMIT_ACTIVE) else $error("no limit");
  a_run_state:
    assert property (1 |=> RUNNING == !($past(HALT) || $past(UNDERVOLTAGE) || $past(OVERHEAT))) else $error("run");
  a_tach_single: assert property (1 |=> TACH_SINGLE_RATE == $past(ROTOR_POSITION_A)) else $error("tach one");
  a_tach_triple:
    assert property (1 |=> TACH_TRIPLE_RATE == ($past(ROTOR_POSITION_A) ^ $past(ROTOR_POSITION_B)
      ^ $past(ROTOR_POSITION_C))) else $error("tach three");
  a_phase_split:
    assert property ($onehot0(SOURCE_DRIVE) && (SOURCE_DRIVE & SINK_DRIVE) == 3'h0) else $error("phase clash");
endmodule : fan_drive_ctrl_monitor

bind fan_drive_ctrl fan_drive_ctrl_monitor fan_drive_ctrl_monitor_i (.*);

// File: verification/hall_motor_model.sv
// hall sensor model walking a rotor through its six sectors
`timescale 1ns/100ps
module hall_motor_model (
  input wire logic clk, step,
  output logic [2:0] hall
);
  localparam logic [2:0] SEQ [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  logic [2:0] pos_reg = 3'h0;
  // one sector forward per step
  always @(posedge clk) if (step) pos_reg <= pos_reg == 3'h5 ? 3'h0 : pos_reg + 3'h1;
  assign hall = SEQ[pos_reg];
endmodule : hall_motor_model

// File: verification/fan_drive_ctrl_tb.sv
// self-checking bench for the fan drive control logic
`timescale 1ns/100ps
module fan_drive_ctrl_tb;
  import fan_drive_pkg::*;
  localparam int P = CARRIER_DIV * 256;
  logic clk = 0, rstn = 0, en = 1, halt = 1, rev = 0, uv = 0, ot = 0, cl = 0, step = 0, t1, t3, lim, run;
  logic [7:0] cmd = 8'h00;
  logic [2:0] hall, src, snk;
  logic [5:0] e;
  logic [5:0] tbl [6] = '{6'h0A, 6'h0C, 6'h14, 6'h11, 6'h21, 6'h22};
  logic [7:0] lvl [3] = '{8'h20, 8'hE0, 8'h80};
  int bad_count = 0, n_checks = 0, cyc = 0, on;
  fan_drive_ctrl fan_drive_ctrl_i (.SYS_CLK(clk), .RESETN(rstn), .CLK_EN(en), .SPEED_COMMAND_LEVEL(cmd),
    .SPEED_COMMAND_LOW_THRESHOLD(CMD_LOW_THRESHOLD_RST), .SPEED_COMMAND_HIGH_THRESHOLD(CMD_HIGH_THRESHOLD_RST),
    .HALT(halt), .REVERSE(rev), .UNDERVOLTAGE(uv), .OVERHEAT(ot), .CURRENT_LIMIT(cl), .ROTOR_POSITION_A(hall[0]),
    .ROTOR_POSITION_B(hall[1]), .ROTOR_POSITION_C(hall[2]), .SOURCE_DRIVE(src), .SINK_DRIVE(snk),
    .TACH_SINGLE_RATE(t1), .TACH_TRIPLE_RATE(t3), .LIMIT_ACTIVE(lim), .RUNNING(run));
  hall_motor_model hall_motor_model_i (.clk(clk), .step(step), .hall(hall));
  // clock and hang ceiling
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic chk(string nm, logic [15:0] x, logic [15:0] g);
    n_checks++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR %s exp %h got %h", nm, x, g);
    end
  endtask : chk
  // apply inputs, optionally move the rotor one sector, let outputs settle
  task automatic go(logic h, logic u, logic o, logic r, logic [7:0] c, logic s);
    @(posedge clk);
    {halt, uv, ot, rev, cmd, step} <= {h, u, o, r, c, s};
    @(posedge clk);
    step <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : go
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    chk("carrier", 16'h0001, 16'(P * CARRIER_MAX_HZ >= CLK_FREQ_HZ));
    for (int r = 0; r < 2; r++) begin
      go(1, 0, 0, rev, 8'hFF, 0);
      go(1, 0, 0, r[0], 8'hFF, 0);
      chk("halted", 16'h0000, 16'({run, src, snk}));
      for (int i = 0; i < 6; i++) begin
        go(0, 0, 0, r[0], 8'hFF, i > 0 || r > 0);
        e = r ? {tbl[i][2:0], tbl[i][5:3]} : tbl[i];
        chk("drive", 16'({1'b1, hall[0], ^hall, e}), 16'({run, t1, t3, src, snk}));
      end
      $display("direction %0d done", r);
    end
    for (int k = 0; k < 3; k++) begin
      go(k == 0, k == 1, k == 2, rev, 8'hFF, 0);
      chk("stop", 16'h0000, 16'({run, src}));
    end
    go(1, 0, 0, rev, 8'h00, 0);
    go(1, 0, 0, 0, 8'h00, 0);
    $display("protection done");
    for (int j = 0; j < 3; j++) begin
      go(0, 0, 0, 0, lvl[j], 0);
      on = 0;
      repeat (P) begin
        @(posedge clk);
        #1;
        on += int'(src !== 3'h0);
      end
      chk("duty", j == 0 ? 16'h0000 : j == 1 ? 16'(P) : 16'h0001, j == 2 ? 16'(on > P * 7 / 16 && on < P * 9 / 16)
        : 16'(on));
    end
    $display("duty done");
    go(0, 0, 0, 0, 8'hFF, 0);
    @(posedge clk);
    cl <= 1'b1;
    @(posedge clk);
    cl <= 1'b0;
    #1;
    chk("limit", 16'({1'b1, 3'h0, tbl[5][2:0]}), 16'({lim, src, snk}));
    repeat (P + 2) @(posedge clk);
    #1;
    chk("limit release", 16'({1'b0, tbl[5][5:3]}), 16'({lim, src}));
    $display("limit done");
    @(posedge clk);
    en <= 1'b0;
    halt <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("freeze", 16'h0001, 16'(run));
    @(posedge clk);
    en <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("unfreeze", 16'h0000, 16'({run, src}));
    $display("freeze done");
    tally_and_finish();
  end
endmodule : fan_drive_ctrl_tb
